// ---- include/fflm_map.svh ----
// fiber frame link: ordered-set codes, field positions, reset values
//------------------------------------------------------------------------
// How it works
// - frames are 32-bit words, 40-bit line coded
// - data frame carries one to 512 words
// - payload sized from words currently buffered
// - epochs: data frames closed by end-of-epoch frame
// - end-of-epoch frame carries last four bytes
// - data frame: pad, start, words, check, ends, flow
// - sync-only frame: pad, start, check, marker end, status end, flow
// - end-of-epoch frame opens with sync-with-payload set
// - start set embeds two user controls, direction
// - status end embeds overflow and not-ready
// - check word inclusion is selectable
// - transmit buffer overflow raises overflow flag
// - stop/go honoured only with flow control
// - off mode: transmitter disabled, receiver decodes
// - off plus fiber port fills buffer, halts
// - copy mode forwards received traffic unchanged
// - fiber mode resets to copy
// - fiber port with copy or raw invalid
// - raw mode streams converter samples, filtered elsewhere
// - raw starts at trigger, ignores delays
// - raw continues until fiber mode changes
// - flow on: wait far ready, full block
//------------------------------------------------------------------------
`ifndef FFLM_MAP_SVH
`define FFLM_MAP_SVH

// mode field encodings and reset value
`define FFLM_MODE_OFF      3'h0
`define FFLM_MODE_COPY     3'h1
`define FFLM_MODE_RAW      3'h2
`define FFLM_MODE_GEN      3'h3
`define FFLM_MODE_APPEND   3'h4
`define FFLM_MODE_RST      `FFLM_MODE_COPY

// frame and buffer sizes
`define FFLM_MAX_WORDS     10'h200
`define FFLM_BUF_DEPTH     10'h200
`define FFLM_AW            9

// ordered sets: tag in [31:16], code in [15:8], embedded bits in [7:0]
`define FFLM_OS_TAG        16'hbc95
`define FFLM_OS_IDLE       8'h01
`define FFLM_OS_SOF        8'h02
`define FFLM_OS_DEND       8'h03
`define FFLM_OS_MEND       8'h04
`define FFLM_OS_SEND       8'h05
`define FFLM_OS_SWP        8'h06
`define FFLM_OS_GO         8'h07
`define FFLM_OS_STOP       8'h08

// embedded bit positions
`define FFLM_SOF_UC1_BIT   0
`define FFLM_SOF_UC2_BIT   1
`define FFLM_SOF_DIR_BIT   2
`define FFLM_SEND_OVF_BIT  0
`define FFLM_SEND_NOT_READY_FLAG_BIT 1

// check word
`define FFLM_CRC_POLY      32'h04c11db7
`define FFLM_CRC_INIT      32'hffffffff

`endif

// ---- include/fflm_pkg.sv ----
// fiber frame link: shared types
`include "fflm_map.svh"

package fflm_pkg;

   typedef enum logic [2:0] {
      FFLM_ST_IDLE = 3'b000,
      FFLM_ST_PAD  = 3'b001,
      FFLM_ST_SOF  = 3'b010,
      FFLM_ST_PAY  = 3'b011,
      FFLM_ST_CRC  = 3'b100,
      FFLM_ST_END  = 3'b101,
      FFLM_ST_STAT = 3'b110,
      FFLM_ST_FLOW = 3'b111
   } fflm_state_type;

   typedef enum logic [1:0] {
      FFLM_FR_DATA = 2'b00,
      FFLM_FR_SYNC = 2'b01,
      FFLM_FR_EPOCH = 2'b10
   } fflm_frame_type;

endpackage

// ---- hw/fflm_mem.sv ----
// fiber frame link: transmit / data buffer storage, registered read
`timescale 1ns/10ps
`include "fflm_map.svh"

module fflm_mem
   import fflm_pkg::*;
(
   input  wire logic                 sys_clk_i,  // system clock
   input  wire logic                 we_i,       // write strobe
   input  wire logic [`FFLM_AW-1:0]  waddr_i,    // write address
   input  wire logic [31:0]          wdata_i,    // write data
   input  wire logic                 re_i,       // read strobe
   input  wire logic [`FFLM_AW-1:0]  raddr_i,    // read address
   output logic      [31:0]          rdata_o     // read data, one cycle late
);

   //---------------------------------------------------------------------
   // storage
   //---------------------------------------------------------------------
   // no reset: contents are only read after being written
   logic [31:0] mem_r [0:(1<<`FFLM_AW)-1];
   logic [31:0] rdata_r;

   always_ff @(posedge sys_clk_i)
   begin
      if (we_i)
      begin
         mem_r[waddr_i] <= wdata_i;
      end
      if (re_i)
      begin
         rdata_r <= mem_r[raddr_i];
      end
   end

   assign rdata_o = rdata_r;

endmodule

// ---- hw/fflm_framer.sv ----
// fiber frame link: mode control, raw framer, copy path, data buffer
`timescale 1ns/10ps
`include "fflm_map.svh"

module fflm_framer
   import fflm_pkg::*;
(
   input  wire logic        sys_clk_i,       // 20 MHz system clock
   input  wire logic        resetn_i,        // async reset, active low
   input  wire logic        mode_wr_i,       // load mode field, pulse
   input  wire logic [2:0]  mode_i,          // new fiber mode
   input  wire logic        crc_en_i,        // include check word
   input  wire logic        flow_en_i,       // honour stop/go
   input  wire logic        sync_en_i,       // sync-only frame per epoch
   input  wire logic        epoch_en_i,      // group data into epochs
   input  wire logic [15:0] epoch_words_i,   // words per epoch, >= 1
   input  wire logic        port_fiber_i,    // data port is fiber
   input  wire logic        user_control_one_i, // control into start
   input  wire logic        user_control_two_i, // control into start
   input  wire logic        dir_i,           // direction into start
   input  wire logic        not_ready_flag_i,// local not ready
   input  wire logic        ovf_clr_i,       // clear overflow, pulse
   input  wire logic        trigger_i,       // trigger event, pulse
   input  wire logic        raw_valid_i,     // raw sample word valid
   input  wire logic [31:0] raw_data_i,      // raw sample word
   input  wire logic        filt_valid_i,    // filtered word valid
   input  wire logic [31:0] filt_data_i,     // filtered word
   input  wire logic        rx_valid_i,      // received word valid
   input  wire logic [31:0] rx_word_i,       // received word
   input  wire logic        rx_is_os_i,      // received word is set
   input  wire logic        rx_go_i,         // far end sent go, pulse
   input  wire logic        rx_stop_i,       // far end sent stop, pulse
   output logic             tx_enable_o,     // transmitter enabled
   output logic             tx_valid_o,      // tx word valid
   output logic [31:0]      tx_word_o,       // tx word to line encoder
   output logic             tx_is_os_o,      // tx word is ordered set
   output logic             filt_ready_o,    // filtered input accepted
   output logic             port_valid_o,    // filtered word to port
   output logic [31:0]      port_data_o,     // filtered word to port
   output logic [2:0]       mode_o,          // current fiber mode
   output logic             transmit_overflow_flag_o, // sticky overflow
   output logic             invalid_cfg_o,   // bad port/mode combo
   output logic             far_go_o         // far end ready
);

   //---------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------
   typedef struct packed {
      logic [2:0]         mode;
      fflm_state_type     st;
      fflm_frame_type     kind;
      logic [9:0]         words_left;
      logic [15:0]        epoch_left;
      logic [31:0]        crc;
      logic               sync_pend;
      logic               far_go;
      logic               raw_armed;
      logic               ovf;
      logic [`FFLM_AW-1:0] wptr;
      logic [`FFLM_AW-1:0] rptr;
      logic [9:0]         cnt;
      logic               tx_en;
      logic               tx_valid;
      logic [31:0]        tx_word;
      logic               tx_os;
      logic               filt_ready;
      logic               port_valid;
      logic [31:0]        port_data;
      logic               invalid;
   } fflm_regs_type;

   fflm_regs_type r_r;
   fflm_regs_type r_nxt;

   logic [31:0]         mem_rdata;
   logic                mem_we;
   logic [31:0]         mem_wdata;
   logic                mem_re;

   //---------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------
   // ordered set word with embedded bits
   function automatic logic [31:0] fflm_os(input logic [7:0] code,
                                           input logic [7:0] emb);
      return {`FFLM_OS_TAG, code, emb};
   endfunction

   // bitwise check-word update over one payload word
   function automatic logic [31:0] fflm_crc(input logic [31:0] c,
                                            input logic [31:0] d);
      logic [31:0] acc;
      logic        fb;
      acc = c;
      for (int i = 31; i >= 0; i--)
      begin
         fb  = acc[31] ^ d[i];
         acc = {acc[30:0], 1'b0};
         if (fb)
         begin
            acc = acc ^ `FFLM_CRC_POLY;
         end
      end
      return acc;
   endfunction

   //---------------------------------------------------------------------
   // buffer
   //---------------------------------------------------------------------
   fflm_mem u_mem (
      .sys_clk_i (sys_clk_i),
      .we_i      (mem_we),
      .waddr_i   (r_r.wptr),
      .wdata_i   (mem_wdata),
      .re_i      (mem_re),
      .raddr_i   (r_r.rptr),
      .rdata_o   (mem_rdata)
   );

   //---------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------
   always_comb
   begin
      logic        full;
      logic        off_fill;
      logic        raw_wr;
      logic [15:0] el1;
      logic [9:0]  blk;
      logic [9:0]  n;
      logic        go_ok;
      logic        rd;
      logic [7:0]  emb;
      full     = 1'b0;
      off_fill = 1'b0;
      raw_wr   = 1'b0;
      el1      = 16'h0000;
      blk      = 10'h000;
      n        = 10'h000;
      go_ok    = 1'b0;
      rd       = 1'b0;
      emb      = 8'h00;
      r_nxt    = r_r;
      r_nxt.tx_valid = 1'b0;
      r_nxt.tx_os    = 1'b0;

      // far end flow state decoded in every mode, even off
      if (!flow_en_i)
      begin
         r_nxt.far_go = 1'b1;
      end
      else if (rx_go_i)
      begin
         r_nxt.far_go = 1'b1;
      end
      else if (rx_stop_i)
      begin
         r_nxt.far_go = 1'b0;
      end

      // invalid when filtered data would share the fiber
      r_nxt.invalid = port_fiber_i && ((r_r.mode == `FFLM_MODE_COPY)
                      || (r_r.mode == `FFLM_MODE_RAW));

      // transmitter enable: off in off mode and in the modes left out
      r_nxt.tx_en = (r_r.mode == `FFLM_MODE_COPY)
                    || (r_r.mode == `FFLM_MODE_RAW);

      // filtered data routing
      full     = (r_r.cnt == `FFLM_BUF_DEPTH);
      off_fill = (r_r.mode == `FFLM_MODE_OFF) && port_fiber_i;
      r_nxt.port_valid = 1'b0;
      if (!port_fiber_i)
      begin
         // filtered data keeps flowing to the other port
         r_nxt.filt_ready = 1'b1;
         r_nxt.port_valid = filt_valid_i;
         r_nxt.port_data  = filt_data_i;
      end
      else
      begin
         // fiber port: fill buffer in off mode, stall once full;
         // stall outright in any other mode
         r_nxt.filt_ready = off_fill && !full;
      end

      // raw arming: first trigger after selecting raw, no delays
      if ((r_r.mode == `FFLM_MODE_RAW) && trigger_i)
      begin
         r_nxt.raw_armed = 1'b1;
      end

      // buffer writes
      raw_wr    = (r_r.mode == `FFLM_MODE_RAW) && r_r.raw_armed
                  && raw_valid_i;
      mem_we    = 1'b0;
      mem_wdata = raw_data_i;
      if (off_fill && filt_valid_i && r_r.filt_ready && !full)
      begin
         mem_we    = 1'b1;
         mem_wdata = filt_data_i;
      end
      else if (raw_wr && !full)
      begin
         mem_we = 1'b1;
      end

      // overflow: a set wins over a same-cycle clear
      if (raw_wr && full)
      begin
         r_nxt.ovf = 1'b1;
      end
      else if (ovf_clr_i)
      begin
         r_nxt.ovf = 1'b0;
      end

      // copy mode forwards the receiver straight through
      if (r_r.mode == `FFLM_MODE_COPY)
      begin
         r_nxt.tx_valid = rx_valid_i;
         r_nxt.tx_word  = rx_word_i;
         r_nxt.tx_os    = rx_is_os_i;
      end

      // block size limit for the next data frame
      el1 = r_r.epoch_left - 16'h0001;
      if (epoch_en_i && (el1 < {6'h00, `FFLM_MAX_WORDS}))
      begin
         blk = el1[9:0];
      end
      else
      begin
         blk = `FFLM_MAX_WORDS;
      end
      n = (r_r.cnt < blk) ? r_r.cnt : blk;
      go_ok = !flow_en_i || r_r.far_go;

      // raw framer
      rd = 1'b0;
      if ((r_r.mode == `FFLM_MODE_RAW) && r_r.tx_en)
      begin
         unique case (r_r.st)
            FFLM_ST_IDLE:
            begin
               if (r_r.sync_pend && go_ok)
               begin
                  r_nxt.kind       = FFLM_FR_SYNC;
                  r_nxt.words_left = 10'h000;
                  r_nxt.sync_pend  = 1'b0;
                  r_nxt.st         = FFLM_ST_PAD;
               end
               else if (epoch_en_i && (r_r.epoch_left <= 16'h0001)
                        && (r_r.cnt != 10'h000) && go_ok)
               begin
                  r_nxt.kind       = FFLM_FR_EPOCH;
                  r_nxt.words_left = 10'h001;
                  r_nxt.st         = FFLM_ST_PAD;
               end
               else if (go_ok && (n != 10'h000)
                        && (!flow_en_i || (r_r.cnt >= blk)))
               begin
                  r_nxt.kind       = FFLM_FR_DATA;
                  r_nxt.words_left = n;
                  r_nxt.st         = FFLM_ST_PAD;
               end
            end
            FFLM_ST_PAD:
            begin
               // end-of-epoch frame replaces the pad
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_os    = 1'b1;
               r_nxt.tx_word  = (r_r.kind == FFLM_FR_EPOCH)
                                ? fflm_os(`FFLM_OS_SWP, 8'h00)
                                : fflm_os(`FFLM_OS_IDLE, 8'h00);
               r_nxt.st       = FFLM_ST_SOF;
            end
            FFLM_ST_SOF:
            begin
               emb = 8'h00;
               emb[`FFLM_SOF_UC1_BIT] = user_control_one_i;
               emb[`FFLM_SOF_UC2_BIT] = user_control_two_i;
               emb[`FFLM_SOF_DIR_BIT] = dir_i;
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_os    = 1'b1;
               r_nxt.tx_word  = fflm_os(`FFLM_OS_SOF, emb);
               r_nxt.crc      = `FFLM_CRC_INIT;
               if (r_r.words_left != 10'h000)
               begin
                  rd       = 1'b1;
                  r_nxt.st = FFLM_ST_PAY;
               end
               else
               begin
                  r_nxt.st = crc_en_i ? FFLM_ST_CRC : FFLM_ST_END;
               end
            end
            FFLM_ST_PAY:
            begin
               // word fetched last cycle leaves now
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_word  = mem_rdata;
               r_nxt.crc      = fflm_crc(r_r.crc, mem_rdata);
               if (r_r.words_left != 10'h000)
               begin
                  rd = 1'b1;
               end
               else
               begin
                  r_nxt.st = crc_en_i ? FFLM_ST_CRC : FFLM_ST_END;
               end
            end
            FFLM_ST_CRC:
            begin
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_word  = r_r.crc;
               r_nxt.st       = FFLM_ST_END;
            end
            FFLM_ST_END:
            begin
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_os    = 1'b1;
               r_nxt.tx_word  = (r_r.kind == FFLM_FR_DATA)
                                ? fflm_os(`FFLM_OS_DEND, 8'h00)
                                : fflm_os(`FFLM_OS_MEND, 8'h00);
               r_nxt.st       = FFLM_ST_STAT;
            end
            FFLM_ST_STAT:
            begin
               emb = 8'h00;
               emb[`FFLM_SEND_OVF_BIT]  = r_r.ovf;
               emb[`FFLM_SEND_NOT_READY_FLAG_BIT] = not_ready_flag_i;
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_os    = 1'b1;
               r_nxt.tx_word  = fflm_os(`FFLM_OS_SEND, emb);
               r_nxt.st       = FFLM_ST_FLOW;
            end
            FFLM_ST_FLOW:
            begin
               // our own readiness goes out as go or stop
               r_nxt.tx_valid = 1'b1;
               r_nxt.tx_os    = 1'b1;
               r_nxt.tx_word  = not_ready_flag_i
                                ? fflm_os(`FFLM_OS_STOP, 8'h00)
                                : fflm_os(`FFLM_OS_GO, 8'h00);
               r_nxt.st       = FFLM_ST_IDLE;
               if (r_r.kind == FFLM_FR_EPOCH)
               begin
                  r_nxt.epoch_left = epoch_words_i;
                  r_nxt.sync_pend  = sync_en_i;
               end
            end
         endcase
      end

      // read bookkeeping, shared by every payload fetch
      mem_re = rd;
      if (rd)
      begin
         r_nxt.rptr       = r_r.rptr + 1'b1;
         r_nxt.words_left = r_r.words_left - 10'h001;
         if (epoch_en_i && (r_r.kind != FFLM_FR_EPOCH))
         begin
            r_nxt.epoch_left = r_r.epoch_left - 16'h0001;
         end
      end
      if (mem_we)
      begin
         r_nxt.wptr = r_r.wptr + 1'b1;
      end
      // mode change, reserved codes refused: it wins over this cycle's framer state and buffer
      // pointers so no stale frame survives into a later session; this cycle's tx word still goes out
      if (mode_wr_i && (mode_i <= `FFLM_MODE_APPEND)
          && (mode_i != r_r.mode))
      begin
         r_nxt.mode       = mode_i;
         r_nxt.st         = FFLM_ST_IDLE;     // mode change ends raw
         r_nxt.raw_armed  = 1'b0;
         r_nxt.sync_pend  = 1'b0;
         r_nxt.epoch_left = epoch_words_i;
         r_nxt.wptr       = '0;
         r_nxt.rptr       = '0;
         r_nxt.cnt        = 10'h000;
      end
      else
      begin
         r_nxt.cnt = r_r.cnt + {9'h000, mem_we} - {9'h000, rd};
      end
   end

   //---------------------------------------------------------------------
   // registers
   //---------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         r_r            <= '0;
         r_r.mode       <= `FFLM_MODE_RST;
         r_r.st         <= FFLM_ST_IDLE;
         r_r.kind       <= FFLM_FR_DATA;
         r_r.far_go     <= 1'b1;
         r_r.tx_en      <= 1'b1;
         r_r.filt_ready <= 1'b1;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   //---------------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------------
   assign tx_enable_o              = r_r.tx_en;
   assign tx_valid_o               = r_r.tx_valid;
   assign tx_word_o                = r_r.tx_word;
   assign tx_is_os_o               = r_r.tx_os;
   assign filt_ready_o             = r_r.filt_ready;
   assign port_valid_o             = r_r.port_valid;
   assign port_data_o              = r_r.port_data;
   assign mode_o                   = r_r.mode;
   assign transmit_overflow_flag_o = r_r.ovf;
   assign invalid_cfg_o            = r_r.invalid;
   assign far_go_o                 = r_r.far_go;

endmodule

// ---- test/fflm_far_model.sv ----
// far-end receiver model: upstream word stream and stop/go pulses
`timescale 1ns/10ps
module fflm_far_model (
   input  wire logic        sys_clk_i,  // system clock
   input  wire logic        run_i,      // send words upstream
   input  wire logic [1:0]  flow_cmd_i, // 1 go, 2 stop
   output logic             rx_valid_o, // word valid
   output logic [31:0]      rx_word_o,  // received word
   output logic             rx_go_o,    // go pulse
   output logic             rx_stop_o   // stop pulse
);
   // idle line flips every bit each cycle, alternating between the inverse and the last word
   initial {rx_valid_o, rx_word_o, rx_go_o, rx_stop_o} = '0;
   always @(posedge sys_clk_i)
   begin
      rx_valid_o <= run_i;
      rx_word_o <= run_i ? rx_word_o + 32'h01010101 : ~rx_word_o;
      rx_go_o <= flow_cmd_i == 2'h1;
      rx_stop_o <= flow_cmd_i == 2'h2;
   end
endmodule

// ---- test/fflm_framer_sva.sv ----
// fiber frame link checker: timing relations at the framer ports
`timescale 1ns/10ps
`include "fflm_map.svh"
module fflm_framer_sva (
   input wire logic        sys_clk_i, resetn_i, mode_wr_i, flow_en_i,
   input wire logic        port_fiber_i, ovf_clr_i, filt_valid_i, rx_valid_i,
   input wire logic        tx_enable_o, tx_valid_o, tx_is_os_o, port_valid_o,
   input wire logic        transmit_overflow_flag_o, invalid_cfg_o, far_go_o,
   input wire logic [2:0]  mode_i, mode_o,
   input wire logic [31:0] filt_data_i, rx_word_i, tx_word_o, port_data_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic [7:0] oc;
   logic       raw_os;
   // raw_os keeps forwarded copy words out of the framing checks
   assign oc = tx_word_o[15:8];
   assign raw_os = mode_o == 3'h2 && tx_valid_o && tx_is_os_o;
   a_mode_load: assert property (mode_wr_i && mode_i < 3'h5
      |=> mode_o == $past(mode_i)) else $error("mode not loaded");
   a_copy_fwd: assert property (mode_o==3'h1 && !mode_wr_i && rx_valid_i
      |=> tx_valid_o && tx_word_o == $past(rx_word_i)) else $error("copy");
   a_off_quiet: assert property (mode_o==3'h0 && $past(mode_o)==3'h0
      |-> !tx_enable_o && !tx_valid_o) else $error("off mode sends");
   a_invalid_cfg: assert property ($past(resetn_i) |->
      invalid_cfg_o == $past(port_fiber_i && mode_o inside {3'h1, 3'h2}))
      else $error("invalid flag wrong");
   a_ovf_sticky: assert property ($fell(transmit_overflow_flag_o)
      |-> $past(ovf_clr_i)) else $error("overflow lost");
   a_filt_echo: assert property (!port_fiber_i && filt_valid_i
      |=> port_valid_o && port_data_o == $past(filt_data_i)) else $error("echo");
   a_far_go: assert property (!flow_en_i [*2] |-> far_go_o)
      else $error("far go not forced");
   a_sof_after_pad: assert property (raw_os && oc==8'h02 && $stable(mode_o)
      |-> $past(tx_valid_o) && $past(oc) inside {8'h01, 8'h06})
      else $error("start set not after pad");
   a_stat_order: assert property (raw_os && oc==8'h05 && $stable(mode_o)
      |-> $past(oc) inside {8'h03, 8'h04} ##1 raw_os && oc inside {8'h07, 8'h08})
      else $error("status set out of order");
   c_epoch: cover property (raw_os && oc == 8'h06);
   c_ovf: cover property (transmit_overflow_flag_o && !far_go_o);
   c_invalid: cover property (invalid_cfg_o);
endmodule
bind fflm_framer fflm_framer_sva u_sva (.*);

// ---- test/test_fiber_frame_link_modes.sv ----
// testbench: mode table, raw framing, flow stall, overflow, fill, reset
`timescale 1ns/10ps
`include "fflm_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_fiber_frame_link_modes import fflm_pkg::*; ;
   logic        clk, rst_n, wr, crc, flow, epo, fib, not_ready_flag, clr, trig, rv;
   logic        xv, go, stp, ten, tv, tos, frdy, pv, ovf, inv, fgo, run;
   logic        fv = 1'b0;
   logic [1:0]  cmd;
   logic [2:0]  mode, mo;
   logic [15:0] ew;
   logic [31:0] rd, xw, tw, pd;
   logic [31:0] fd = '0;
   int          err_count = 0, compares = 0, s, p;
   logic [6:0]  rows [7] = '{7'h00, 7'h36, 7'h48, 7'h68, 7'h25, 7'h75, 7'h13};
   fflm_far_model far (.sys_clk_i(clk), .run_i(run), .flow_cmd_i(cmd),
      .rx_valid_o(xv), .rx_word_o(xw), .rx_go_o(go), .rx_stop_o(stp));
   fflm_framer dut (.sys_clk_i(clk), .resetn_i(rst_n), .mode_wr_i(wr),
      .mode_i(mode), .crc_en_i(crc), .flow_en_i(flow), .sync_en_i(1'b0),
      .epoch_en_i(epo), .epoch_words_i(ew), .port_fiber_i(fib),
      .user_control_one_i(1'b1), .user_control_two_i(1'b0), .dir_i(1'b1),
      .not_ready_flag_i(not_ready_flag), .ovf_clr_i(clr), .trigger_i(trig),
      .raw_valid_i(rv), .raw_data_i(rd), .filt_valid_i(fv),
      .filt_data_i(fd), .rx_valid_i(xv), .rx_word_i(xw), .rx_is_os_i(1'b0),
      .rx_go_i(go), .rx_stop_i(stp), .tx_enable_o(ten), .tx_valid_o(tv),
      .tx_word_o(tw), .tx_is_os_o(tos), .filt_ready_o(frdy),
      .port_valid_o(pv), .port_data_o(pd), .mode_o(mo),
      .transmit_overflow_flag_o(ovf), .invalid_cfg_o(inv), .far_go_o(fgo));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // filtered words every other cycle so the echo path sees gaps
   always @(negedge clk)
   begin
      fv <= ~fv;
      fd <= fd + 32'h1;
   end
   // check word over one payload word: msb first, no final inversion
   function automatic logic [31:0] crc_of(input logic [31:0] d);
      crc_of = `FFLM_CRC_INIT;
      for (int i = 31; i >= 0; i--)
         crc_of = {crc_of[30:0], 1'b0}
                  ^ ((crc_of[31] ^ d[i]) ? `FFLM_CRC_POLY : 32'h0);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic setm(input logic [2:0] m);
      wr = 1'b1;
      mode = m;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   // counts words sent and non-ordered-set words among them, check word included
   task automatic watch(input int n);
      repeat (n)
      begin
         cyc(1);
         s += (tv === 1'b1);
         p += (tv === 1'b1 && tos === 1'b0);
      end
   endtask
   task automatic frame(input logic [31:0] w, input logic [7:0] pad, ec);
      logic [31:0] q [$];
      rv = 1'b1;
      rd = w;
      cyc(1);
      rv = 1'b0;
      repeat (16)
      begin
         cyc(1);
         if (tv === 1'b1) q.push_back(tw);
      end
      `CHK(q.size(), 6 + crc)
      `CHK(q[0][31:8], {`FFLM_OS_TAG, pad})
      `CHK(q[1], {`FFLM_OS_TAG, `FFLM_OS_SOF, 8'h05})
      `CHK(q[2], w)
      if (crc) `CHK(q[3], crc_of(w))
      `CHK(q[3 + crc][31:8], {`FFLM_OS_TAG, ec})
      `CHK(q[4 + crc], {`FFLM_OS_TAG, 8'h05, 6'h0, not_ready_flag, 1'b0})
      `CHK(q[5 + crc][15:8], not_ready_flag ? 8'h08 : 8'h07)
   endtask
   task automatic complete_run;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      {wr, flow, epo, fib, not_ready_flag, clr, trig, rv, run, mode, cmd} = '0;
      crc = 1'b0; // first raw frame goes out without a check word
      {ew, rd} = '0;
      rst_n = 1'b0;
      cyc(1);
      `CHK(mo, `FFLM_MODE_RST)
      `CHK({ten, frdy, fgo, ovf, inv}, 5'h1c)
      cyc(2);
      rst_n = 1'b1;
      run = 1'b1;
      foreach (rows[i])
      begin
         setm(rows[i][6:4]);
         `CHK(mo, rows[i][3:1])
         `CHK(ten, rows[i][0])
      end
      // raw words before the trigger must not leave the block
      run = 1'b0;
      setm(`FFLM_MODE_RAW);
      s = 0;
      rv = 1'b1;
      cyc(1);
      rv = 1'b0;
      watch(10);
      `CHK(s, 0)
      for (int f = 0; f < 3; f++)
      begin
         if (f == 2) setm(`FFLM_MODE_OFF);
         if (f == 2) setm(`FFLM_MODE_RAW);
         if (f != 1) trig = 1'b1;
         cyc(1);
         trig = 1'b0;
         frame(32'h1234abcd + f, f == 2 ? `FFLM_OS_SWP : `FFLM_OS_IDLE,
            f == 2 ? `FFLM_OS_MEND : `FFLM_OS_DEND);
         {crc, not_ready_flag, epo, ew} = {1'b1, 1'b1, f == 1, 16'h1};
         if (f == 1) crc = 1'b0;
      end
      // far end stops us: a full block waits, the extra word is lost
      {epo, flow, cmd} = {1'b0, 1'b1, 2'h2};
      cyc(1);
      cmd = 2'h0;
      cyc(3);
      `CHK(fgo, 1'b0)
      {s, rv} = {32'h0, 1'b1};
      repeat (513)
      begin
         rd = rd + 32'h1;
         watch(1);
      end
      rv = 1'b0;
      cyc(2);
      `CHK(s, 0)
      `CHK(ovf, 1'b1)
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(1);
      `CHK(ovf, 1'b0)
      {p, cmd} = {32'h0, 2'h1};
      cyc(1);
      cmd = 2'h0;
      watch(560);
      `CHK(p, 512 + crc)
      flow = 1'b0;
      setm(`FFLM_MODE_OFF);
      fib = 1'b1;
      cyc(1100);
      `CHK(frdy, 1'b0)
      `CHK(inv, 1'b0)
      setm(`FFLM_MODE_COPY);
      `CHK(inv, 1'b1)
      rst_n = 1'b0;
      cyc(1);
      `CHK(mo, `FFLM_MODE_RST)
      rst_n = 1'b1;
      cyc(2);
      complete_run();
   end
   // cut a hang short well past the expected run length
   initial
   begin
      #500000;
      err_count++;
      complete_run();
   end
endmodule
